// [design/irqfp_pkg.sv]
`default_nettype none
package irqfp_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [9:0] IDX_EXT_FLAGS   = 10'h091;
	localparam logic [9:0] IDX_LEVEL_PRI   = 10'h0b8;
	localparam logic [9:0] IDX_LEVEL_EXT   = 10'h0f8;
	// block-local registers, byte addresses
	localparam logic [11:0] ADDR_CTRL      = 12'h000;
	localparam logic [11:0] ADDR_STATUS    = 12'h004;
	localparam logic [11:0] ADDR_CLEAR     = 12'h008;
	localparam logic [11:0] ADDR_IRQ_EN    = 12'h00c;
	localparam logic [11:0] ADDR_SERVICE   = 12'h010;

	// extended_request_flags fields
	localparam int XF_TIMER3 = 7;
	localparam int XF_CONV   = 6;
	localparam int XF_TIMER2 = 5;
	localparam int XF_RADIO  = 4;
	localparam logic [7:0] XF_RW_MASK  = 8'hf0;
	localparam logic [7:0] XF_RD_ONES  = 8'h08;
	localparam logic [7:0] XF_RESET    = 8'h00;

	// irq_level_select_primary fields
	localparam int LP_SERIAL1 = 6;
	localparam int LP_SERIAL0 = 4;
	localparam int LP_TIMER1  = 3;
	localparam int LP_EXT1    = 2;
	localparam int LP_TIMER0  = 1;
	localparam int LP_EXT0    = 0;
	localparam logic [7:0] LP_RW_MASK  = 8'h5f;
	localparam logic [7:0] LP_RD_ONES  = 8'h80;
	localparam logic [7:0] LP_RESET    = 8'h00;

	// irq_level_select_extended fields
	localparam int LE_RTC    = 4;
	localparam int LE_TIMER3 = 3;
	localparam int LE_CONV   = 2;
	localparam int LE_TIMER2 = 1;
	localparam int LE_RADIO  = 0;
	localparam logic [7:0] LE_RW_MASK  = 8'h1f;
	localparam logic [7:0] LE_RD_ONES  = 8'he0;
	localparam logic [7:0] LE_RESET    = 8'h00;

	// natural priority numbers, 0 is served first
	localparam int NSRC       = 12;
	localparam int NP_EXT0    = 0;
	localparam int NP_TIMER0  = 1;
	localparam int NP_EXT1    = 2;
	localparam int NP_TIMER1  = 3;
	localparam int NP_SERIAL0 = 4;
	localparam int NP_TIMER2  = 5;
	localparam int NP_SERIAL1 = 6;
	localparam int NP_RADIO   = 7;
	localparam int NP_CONV    = 8;
	localparam int NP_TIMER3  = 10;
	localparam int NP_RTC     = 11;
	localparam logic [3:0] ID_FLASH_DEBUG = 4'hc;

	// control register fields
	localparam int CT_GLOBAL  = 12;
	localparam int CT_FLASH   = 13;
	localparam int CT_SENSE_A = 14;
	localparam int CT_SENSE_B = 15;
	localparam logic [15:0] CT_RW_MASK = 16'hfdff;
	localparam logic [15:0] CT_RESET   = 16'h0000;
	localparam int NEV = 6;

	typedef enum logic [1:0] {
		LVL_NONE, LVL_LOW, LVL_HIGH, LVL_HIGHEST
	} irqfp_level_t;

	// request presented to the core
	typedef struct packed {
		logic         valid;
		irqfp_level_t level;
		logic [3:0]   id;
	} irqfp_req_t;
endpackage
`default_nettype wire

// [design/irqfp_top.sv]
// Overview of operation
// R1: timer three request sets extended flag bit 7.
// R2: converter or cipher request sets shared flag bit 6.
// R3: shared flag takes a source only when its local enable is set.
// R4: timer two request sets extended flag bit 5.
// R5: radio request sets extended flag bit 4.
// R6: software may set the flags; only software clears them.
// R7: level decides first, natural order only within one level.
// R8: enabled flash/debug source alone occupies the highest level.
// R9: every other source is low or high by its level select bit.
// R10: among equal-level requests the lowest natural number wins.
// R11: a running routine is preempted only by a strictly higher level.
// R12: primary level bits: serial1 6, serial0 4, timer1 3, pins 2 and 0, timer0 1.
// R13: extended level bits: rtc 4, timer3 3, converter 2, timer2 1, radio 0.
// R14: two external pins, each level or edge sensitive by a select bit.
// R15: global enable clear masks all but flash/debug, which has its own.
// R16: an enabled pin pulse longer than eight cycles always requests.
// R17: timer three has natural number 10, real-time clock 11.
// R18: reserved bits ignore writes and read their fixed values.
// R19: a request shows only while its flag and enables allow it.
`default_nettype none
module irqfp_top
	import irqfp_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// peripheral request pulses, same clock
	input  wire logic        timer_three_req,
	input  wire logic        timer_two_req,
	input  wire logic        radio_req,
	input  wire logic        converter_local_flag,
	input  wire logic        converter_local_enable,
	input  wire logic        cipher_local_flag,
	input  wire logic        cipher_local_enable,
	// flag levels held by other peripherals
	input  wire logic        timer_zero_flag,
	input  wire logic        timer_one_flag,
	input  wire logic        serial_zero_flag,
	input  wire logic        serial_one_flag,
	input  wire logic        rtc_flag,
	input  wire logic        flash_debug_flag,
	// external interrupt pins, active low, asynchronous
	input  wire logic        ext_pin_zero_n,
	input  wire logic        ext_pin_one_n,
	// core side
	input  wire logic        irq_take,
	input  wire logic        irq_return,
	output irqfp_req_t       irq_req,
	// event interrupt
	output logic             irq
);

	// bus decode
	logic        setup;
	logic        wr;
	logic [11:0] a;
	logic        hit_xf;
	logic        hit_lp;
	logic        hit_le;
	logic        hit_ct;
	logic        hit_st;
	logic        hit_cl;
	logic        hit_en;
	logic        hit_sv;
	logic        mapped;

	assign setup  = psel && !penable;
	assign wr     = psel && penable && pwrite && pready;
	assign a      = paddr;
	assign hit_xf = (a == {IDX_EXT_FLAGS, 2'b00});
	assign hit_lp = (a == {IDX_LEVEL_PRI, 2'b00});
	assign hit_le = (a == {IDX_LEVEL_EXT, 2'b00});
	assign hit_ct = (a == ADDR_CTRL);
	assign hit_st = (a == ADDR_STATUS);
	assign hit_cl = (a == ADDR_CLEAR);
	assign hit_en = (a == ADDR_IRQ_EN);
	assign hit_sv = (a == ADDR_SERVICE);
	assign mapped = hit_xf | hit_lp | hit_le | hit_ct | hit_st | hit_cl
		| hit_en | hit_sv;

	// register state
	logic [7:0]     xflags_q;
	logic [7:0]     lvl_pri_q;
	logic [7:0]     lvl_ext_q;
	logic [15:0]    ctrl_q;
	logic [NEV-1:0] status_q;
	logic [NEV-1:0] irq_en_q;
	logic [2:0]     active_q;
	logic [1:0]     ext_edge_q;

	// hardware set terms for the extended flags
	logic conv_req;
	logic [7:0] xf_set;

	assign conv_req = (converter_local_flag && converter_local_enable) // R3
		|| (cipher_local_flag && cipher_local_enable); // R2
	always_comb begin
		xf_set            = 8'h00;
		xf_set[XF_TIMER3] = timer_three_req; // R1
		xf_set[XF_CONV]   = conv_req; // R2
		xf_set[XF_TIMER2] = timer_two_req; // R4
		xf_set[XF_RADIO]  = radio_req; // R5
	end

	// a hardware set in the write cycle wins, so no request is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xflags_q <= XF_RESET;
		end else if (wr && hit_xf) begin
			xflags_q <= (pwdata[7:0] & XF_RW_MASK) | xf_set; // R6 R18
		end else begin
			xflags_q <= xflags_q | xf_set; // R6
		end
	end

	// level select registers; reserved bits are never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_pri_q <= LP_RESET;
			lvl_ext_q <= LE_RESET;
		end else if (wr) begin
			if (hit_lp) begin
				lvl_pri_q <= pwdata[7:0] & LP_RW_MASK; // R12 R18
			end
			if (hit_le) begin
				lvl_ext_q <= pwdata[7:0] & LE_RW_MASK; // R13 R18
			end
		end
	end

	// control: source enables, global and flash enables, sense selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CT_RESET;
		end else if (wr && hit_ct) begin
			ctrl_q <= pwdata[15:0] & CT_RW_MASK;
		end
	end

	// external pins: three stages, a change counts once stages two and
	// three agree, so a one-cycle glitch never reaches the flags
	logic [2:0] sync0_q;
	logic [2:0] sync1_q;
	logic [1:0] pin_lvl_q;
	logic [1:0] pin_fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync0_q   <= 3'h7;
			sync1_q   <= 3'h7;
			pin_lvl_q <= 2'h3;
		end else begin
			sync0_q <= {sync0_q[1:0], ext_pin_zero_n};
			sync1_q <= {sync1_q[1:0], ext_pin_one_n};
			if (sync0_q[1] == sync0_q[2]) begin
				pin_lvl_q[0] <= sync0_q[2];
			end
			if (sync1_q[1] == sync1_q[2]) begin
				pin_lvl_q[1] <= sync1_q[2];
			end
		end
	end

	// falling edge seen when both agreeing stages are low; a pulse
	// longer than eight cycles always gets through the filter
	assign pin_fall[0] = pin_lvl_q[0] && !sync0_q[1] && !sync0_q[2]; // R16
	assign pin_fall[1] = pin_lvl_q[1] && !sync1_q[1] && !sync1_q[2]; // R16

	// core taking a request, decoded once for all consumers
	logic take_ok;
	assign take_ok = irq_take && irq_req.valid;

	// edge flags: set by a falling edge, cleared when the core takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_edge_q <= 2'h0;
		end else begin
			ext_edge_q[0] <= pin_fall[0] || (ext_edge_q[0] && !(take_ok
				&& irq_req.id == 4'(NP_EXT0)));
			ext_edge_q[1] <= pin_fall[1] || (ext_edge_q[1] && !(take_ok
				&& irq_req.id == 4'(NP_EXT1)));
		end
	end

	// pin request: low level or latched edge per sense select
	logic [1:0] ext_flag;
	assign ext_flag[0] = ctrl_q[CT_SENSE_A] ? ext_edge_q[0]
		: !pin_lvl_q[0]; // R14
	assign ext_flag[1] = ctrl_q[CT_SENSE_B] ? ext_edge_q[1]
		: !pin_lvl_q[1]; // R14

	// flags and levels gathered in natural order; slot 9 is unused
	logic [NSRC-1:0] flag_v;
	logic [NSRC-1:0] lvl_v;
	always_comb begin
		flag_v             = '0;
		flag_v[NP_EXT0]    = ext_flag[0];
		flag_v[NP_TIMER0]  = timer_zero_flag;
		flag_v[NP_EXT1]    = ext_flag[1];
		flag_v[NP_TIMER1]  = timer_one_flag;
		flag_v[NP_SERIAL0] = serial_zero_flag;
		flag_v[NP_TIMER2]  = xflags_q[XF_TIMER2];
		flag_v[NP_SERIAL1] = serial_one_flag;
		flag_v[NP_RADIO]   = xflags_q[XF_RADIO];
		flag_v[NP_CONV]    = xflags_q[XF_CONV];
		flag_v[NP_TIMER3]  = xflags_q[XF_TIMER3]; // R17
		flag_v[NP_RTC]     = rtc_flag; // R17
		lvl_v              = '0;
		lvl_v[NP_EXT0]     = lvl_pri_q[LP_EXT0]; // R9 R12
		lvl_v[NP_TIMER0]   = lvl_pri_q[LP_TIMER0]; // R12
		lvl_v[NP_EXT1]     = lvl_pri_q[LP_EXT1]; // R12
		lvl_v[NP_TIMER1]   = lvl_pri_q[LP_TIMER1]; // R12
		lvl_v[NP_SERIAL0]  = lvl_pri_q[LP_SERIAL0]; // R12
		lvl_v[NP_SERIAL1]  = lvl_pri_q[LP_SERIAL1]; // R12
		lvl_v[NP_TIMER2]   = lvl_ext_q[LE_TIMER2]; // R13
		lvl_v[NP_RADIO]    = lvl_ext_q[LE_RADIO]; // R13
		lvl_v[NP_CONV]     = lvl_ext_q[LE_CONV]; // R13
		lvl_v[NP_TIMER3]   = lvl_ext_q[LE_TIMER3]; // R13
		lvl_v[NP_RTC]      = lvl_ext_q[LE_RTC]; // R9 R13
	end

	// pending only while flag and enables hold: source and global, flash/debug its own
	logic [NSRC-1:0] pend;
	logic [NSRC-1:0] pend_hi;
	logic [NSRC-1:0] pend_lo;
	logic            fd_pend;
	assign pend    = flag_v & ctrl_q[NSRC-1:0]
		& {NSRC{ctrl_q[CT_GLOBAL]}}; // R15 R19
	assign pend_hi = pend & lvl_v; // R9
	assign pend_lo = pend & ~lvl_v; // R9
	assign fd_pend = flash_debug_flag && ctrl_q[CT_FLASH]; // R8 R15

	// level of the routine in progress is the top active bit
	irqfp_level_t cur_lvl;
	always_comb begin
		if (active_q[2]) begin
			cur_lvl = LVL_HIGHEST;
		end else if (active_q[1]) begin
			cur_lvl = LVL_HIGH;
		end else if (active_q[0]) begin
			cur_lvl = LVL_LOW;
		end else begin
			cur_lvl = LVL_NONE;
		end
	end

	// level first, then the lowest natural number within that level
	irqfp_level_t cand_lvl;
	logic [3:0]   cand_id;
	always_comb begin
		cand_lvl = LVL_NONE;
		cand_id  = 4'h0;
		if (fd_pend) begin
			cand_lvl = LVL_HIGHEST; // R8
			cand_id  = ID_FLASH_DEBUG;
		end else if (|pend_hi) begin
			cand_lvl = LVL_HIGH; // R7
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (pend_hi[i]) begin
					cand_id = 4'(i); // R10
				end
			end
		end else if (|pend_lo) begin
			cand_lvl = LVL_LOW; // R7
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (pend_lo[i]) begin
					cand_id = 4'(i); // R10
				end
			end
		end
	end

	// request register, recomputed every cycle so a cleared flag
	// withdraws its request one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req <= '0;
		end else begin
			irq_req.valid <= (cand_lvl > cur_lvl) && !take_ok; // R11 R19
			irq_req.level <= cand_lvl;
			irq_req.id    <= cand_id;
		end
	end

	// nesting record: taking marks the level busy, return frees the top
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= 3'h0;
		end else if (take_ok) begin
			active_q[irq_req.level - 2'd1] <= 1'b1; // R11
		end else if (irq_return) begin
			if (active_q[2]) begin
				active_q[2] <= 1'b0;
			end else if (active_q[1]) begin
				active_q[1] <= 1'b0;
			end else begin
				active_q[0] <= 1'b0;
			end
		end
	end

	// event status: hardware flag sets and pin edges
	logic [NEV-1:0] ev;
	assign ev = {pin_fall, xf_set[7:4]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
		end else if (wr && hit_cl) begin
			status_q <= (status_q & ~pwdata[NEV-1:0]) | ev; // set wins
		end else begin
			status_q <= status_q | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= '0;
		end else if (wr && hit_en) begin
			irq_en_q <= pwdata[NEV-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & irq_en_q);
		end
	end

	// read mux; reserved bits fixed, clear register reads zero
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		if (hit_xf) begin
			rd[7:0] = (xflags_q & XF_RW_MASK) | XF_RD_ONES; // R18
		end else if (hit_lp) begin
			rd[7:0] = lvl_pri_q | LP_RD_ONES; // R18
		end else if (hit_le) begin
			rd[7:0] = lvl_ext_q | LE_RD_ONES; // R18
		end else if (hit_ct) begin
			rd[15:0] = ctrl_q;
		end else if (hit_st) begin
			rd[NEV-1:0] = status_q;
		end else if (hit_en) begin
			rd[NEV-1:0] = irq_en_q;
		end else if (hit_sv) begin
			rd[2:0] = active_q;
			rd[5:4] = pin_lvl_q;
		end
	end

	// one registered answer per transfer: ready in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= pwrite ? 32'h0000_0000 : rd;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule // irqfp_top
`default_nettype wire

// [test/irqfp_core_model.sv]
`default_nettype none
module irqfp_core_model
	import irqfp_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// request from the block and bench commands
	input  wire irqfp_req_t irq_req,
	input  wire logic       accept,
	input  wire logic       ret_cmd,
	// core handshake
	output logic            irq_take,
	output logic            irq_return
);
	timeunit 1ns;
	timeprecision 1ns;
	// single take per request: a held take would meet a dropped valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_take <= 1'b0;
		end else begin
			irq_take <= accept && irq_req.valid && !irq_take;
		end
	end
	// return only on command, one cycle after the bench raises ret_cmd
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_return <= 1'b0;
		end else begin
			irq_return <= ret_cmd;
		end
	end
endmodule // irqfp_core_model
`default_nettype wire

// [test/irqfp_monitor.sv]
`default_nettype none
module irqfp_monitor
	import irqfp_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// apb handshake
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// core side and level flags
	input wire logic       irq_take,
	input wire irqfp_req_t irq_req,
	input wire logic       flash_debug_flag,
	input wire logic       rtc_flag,
	input wire logic       timer_zero_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// one wait-free access cycle, then the answer goes away
	AST_APB_ONE_WAIT:
		assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not in the access cycle");
	AST_ERR_WITH_READY:
		assert property (pslverr |-> pready)
		else $error("error response without ready");
	AST_VALID_HAS_LEVEL:
		assert property (irq_req.valid |-> irq_req.level != LVL_NONE)
		else $error("request presented with no level");
	AST_HIGHEST_ONLY_FLASH:
		assert property (irq_req.valid && irq_req.level == LVL_HIGHEST
			|-> irq_req.id == ID_FLASH_DEBUG)
		else $error("other source at the highest level");
	AST_FLASH_AT_HIGHEST:
		assert property (irq_req.valid && irq_req.id == ID_FLASH_DEBUG
			|-> irq_req.level == LVL_HIGHEST)
		else $error("flash request below the highest level");
	AST_TAKE_WITHDRAWS:
		assert property (irq_take && irq_req.valid |=> !irq_req.valid)
		else $error("request still shown after take");
	AST_NO_SPARE_ID:
		assert property (irq_req.valid |-> irq_req.id != 4'h9
			&& irq_req.id <= 4'hc)
		else $error("request carries an unused number");
	AST_RTC_CAUSE:
		assert property (irq_req.valid && irq_req.id == 4'hb
			|-> $past(rtc_flag))
		else $error("clock request without its flag");
	AST_FLASH_CAUSE:
		assert property (irq_req.valid && irq_req.id == ID_FLASH_DEBUG
			|-> $past(flash_debug_flag))
		else $error("flash request without its flag");
	AST_TIMER0_CAUSE:
		assert property (irq_req.valid && irq_req.id == 4'h1
			|-> $past(timer_zero_flag))
		else $error("timer zero request without its flag");
endmodule // irqfp_monitor

bind irqfp_top irqfp_monitor mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .irq_take(irq_take),
	.irq_req(irq_req), .flash_debug_flag(flash_debug_flag),
	.rtc_flag(rtc_flag), .timer_zero_flag(timer_zero_flag)
);
`default_nettype wire

// [test/test_irq_flag_priority_unit.sv]
`default_nettype none
module test_irq_flag_priority_unit
	import irqfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A_XF = {IDX_EXT_FLAGS, 2'b00};
	localparam logic [11:0] A_LP = {IDX_LEVEL_PRI, 2'b00};
	localparam logic [11:0] A_LE = {IDX_LEVEL_EXT, 2'b00};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        t3, t2, rad, cf, ce, pf, pe, f0, f1, s0, s1, rtc, fd;
	logic        p0, p1, take, ret, acc, rc, irq, e;
	irqfp_req_t  req;
	int          miscompares, cmp_count;

	irqfp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_three_req(t3), .timer_two_req(t2), .radio_req(rad),
		.converter_local_flag(cf), .converter_local_enable(ce),
		.cipher_local_flag(pf), .cipher_local_enable(pe),
		.timer_zero_flag(f0), .timer_one_flag(f1), .serial_zero_flag(s0),
		.serial_one_flag(s1), .rtc_flag(rtc), .flash_debug_flag(fd),
		.ext_pin_zero_n(p0), .ext_pin_one_n(p1), .irq_take(take),
		.irq_return(ret), .irq_req(req), .irq(irq));
	irqfp_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(req),
		.accept(acc), .ret_cmd(rc), .irq_take(take), .irq_return(ret));

	// free-running core clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task test_done;
		$display("counts: %0d miscompares, %0d compares", miscompares,
			cmp_count);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// apb transfer; the wait is bounded so a dead slave ends the run
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		// an idle edge first, so psel is never driven twice in one step
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			test_done();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	function automatic logic [31:0] rq(irqfp_level_t l, logic [3:0] id);
		return {25'h0, 1'b1, l, id};
	endfunction
	task nv;
		chk({31'h0, req.valid}, 32'h0);
	endtask
	task pulse_ret;
		rc <= 1'b1;
		tick(1);
		rc <= 1'b0;
		tick(1);
	endtask
	task take_one;
		acc <= 1'b1;
		tick(3);
		acc <= 1'b0;
		tick(2);
	endtask

	// reset values, fixed bits, software set and an unmapped place
	task s_regs;
		rd(A_XF, 32'h08);
		rd(A_LP, 32'h80);
		rd(A_LE, 32'he0);
		wr(A_XF, 32'hff);
		rd(A_XF, 32'hf8);
		wr(A_LP, 32'hff);
		rd(A_LP, 32'hdf);
		wr(A_LE, 32'hff);
		rd(A_LE, 32'hff);
		wr(A_XF, 32'h0);
		wr(A_LP, 32'h0);
		wr(A_LE, 32'h0);
		rd(12'h100, 32'h0);
		chk({31'h0, e}, 32'h1);
	endtask
	// edge sense on pin zero, level sense on pin one
	task s_pins;
		wr(ADDR_CTRL, 32'h5005);
		p0 <= 1'b0;
		tick(9);
		p0 <= 1'b1;
		tick(8);
		chk({25'h0, req}, rq(LVL_LOW, 4'h0));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(r & 32'h30, 32'h10);
		take_one();
		pulse_ret();
		tick(2);
		nv();
		p1 <= 1'b0;
		tick(8);
		chk({25'h0, req}, rq(LVL_LOW, 4'h2));
		p1 <= 1'b1;
		tick(8);
		nv();
		wr(ADDR_CTRL, 32'h1005);
		p0 <= 1'b0;
		tick(8);
		chk({25'h0, req}, rq(LVL_LOW, 4'h0));
		p0 <= 1'b1;
		tick(8);
		nv();
		wr(ADDR_CLEAR, 32'h3f);
	endtask
	// hardware sets, local enables, status interrupt raise, mask, clear
	task s_hw;
		cf <= 1'b1;
		pf <= 1'b1;
		t3 <= 1'b1;
		t2 <= 1'b1;
		rad <= 1'b1;
		tick(1);
		t3 <= 1'b0;
		t2 <= 1'b0;
		rad <= 1'b0;
		tick(2);
		rd(A_XF, 32'hb8);
		pe <= 1'b1;
		tick(2);
		rd(A_XF, 32'hf8);
		pe <= 1'b0;
		wr(A_XF, 32'hb0);
		ce <= 1'b1;
		tick(2);
		rd(A_XF, 32'hf8);
		ce <= 1'b0;
		rd(ADDR_STATUS, 32'h0f);
		chk({31'h0, irq}, 32'h0);
		wr(ADDR_IRQ_EN, 32'h1);
		tick(2);
		chk({31'h0, irq}, 32'h1);
		wr(ADDR_CLEAR, 32'h1);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		rd(ADDR_STATUS, 32'h0e);
		rd(A_XF, 32'hf8);
	endtask
	// levels, natural order, preemption and the flash source
	task s_prio;
		static logic [7:0] tb [9] = '{8'h66, 8'h44, 8'h33,
			8'h11, 8'h4b, 8'h3a, 8'h28, 8'h15, 8'h07};
		wr(ADDR_CTRL, 32'h1fff);
		{f0, f1, s0, s1, rtc} <= 5'h1f;
		tick(3);
		chk({25'h0, req}, rq(LVL_LOW, 4'h1));
		for (int i = 0; i < 9; i++) begin
			wr(i < 4 ? A_LP : A_LE, 32'h1 << tb[i][7:4]);
			tick(3);
			chk({25'h0, req}, rq(LVL_HIGH, tb[i][3:0]));
			wr(i < 4 ? A_LP : A_LE, 32'h0);
		end
		wr(A_LE, 32'h10);
		tick(3);
		chk({25'h0, req}, rq(LVL_HIGH, 4'hb));
		take_one();
		nv();
		apb(1'b0, ADDR_SERVICE, 32'h0);
		chk(r & 32'h7, 32'h2);
		fd <= 1'b1;
		wr(ADDR_CTRL, 32'h2fff);
		tick(3);
		chk({25'h0, req}, rq(LVL_HIGHEST, ID_FLASH_DEBUG));
		take_one();
		fd <= 1'b0;
		pulse_ret();
		pulse_ret();
		tick(2);
		nv();
		wr(ADDR_CTRL, 32'h1fff);
		tick(3);
		chk({25'h0, req}, rq(LVL_HIGH, 4'hb));
	endtask

	// reset for ten cycles, then the scenarios in turn
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{t3, t2, rad, cf, ce, pf, pe, f0, f1, s0, s1, rtc, fd} = '0;
		{p0, p1, acc, rc} = 4'b1100;
		miscompares = 0;
		cmp_count = 0;
		presetn = 1'b0;
		tick(10);
		presetn <= 1'b1;
		tick(1);
		s_regs();
		s_pins();
		s_hw();
		s_prio();
		test_done();
	end
endmodule // test_irq_flag_priority_unit
`default_nettype wire
